// ==== core/pgc_pkg.sv ====
// pgc_pkg: register map, field positions and encodings of one pwm generator channel
// assumes a 32-bit apb slave with registers on aligned words, data in the low 16 bits
package pgc_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DUTY = 8'h04;
    localparam logic [7:0] OFF_LDUTY = 8'h08;
    localparam logic [7:0] OFF_PHASE = 8'h0C;
    localparam logic [7:0] OFF_LPHASE = 8'h10;
    localparam logic [7:0] OFF_DT = 8'h14;
    localparam logic [7:0] OFF_ALTDT = 8'h18;
    localparam logic [7:0] OFF_TRIG = 8'h1C;
    localparam logic [7:0] OFF_CFG = 8'h20;
    localparam logic [7:0] OFF_MDUTY = 8'h24;
    localparam logic [7:0] OFF_MPER = 8'h28;
    localparam logic [7:0] OFF_STAT = 8'h2C;
    // generator_control fields
    localparam int CTRL_TRGSTAT = 13;
    localparam int CTRL_TRGIEN = 10;
    localparam int CTRL_ITB = 9;
    localparam int CTRL_MDS = 8;
    localparam int CTRL_DTC_HI = 7;
    localparam int CTRL_DTC_LO = 6;
    localparam int CTRL_POL = 5;
    localparam int CTRL_TBS = 3;
    localparam int CTRL_CAM = 2;
    localparam int CTRL_XPR = 1;
    localparam int CTRL_IUE = 0;
    localparam logic [15:0] CTRL_WMASK = 16'h07EF;
    localparam logic [15:0] DT_MASK = 16'h3FFF;
    localparam logic [15:0] TRIG_MASK = 16'hF03F;
    localparam int TRIG_DIV_LO = 12;
    // cfg register fields
    localparam int CFG_EN = 0;
    localparam int CFG_PIN_PAIR_MODE_LO = 1;
    localparam int CFG_CURRENT_LIMIT_MODE_EN = 3;
    localparam int CFG_SECONDARY = 4;
    localparam logic [15:0] CFG_WMASK = 16'h001F;
    localparam logic [15:0] RESET_ZERO = 16'h0000;
    localparam logic [15:0] MPER_RESET = 16'hFFFF;
    typedef enum logic [1:0] {
        PGC_DT_POS = 2'b00,
        PGC_DT_NEG = 2'b01,
        PGC_DT_OFF = 2'b10,
        PGC_DT_COMP = 2'b11
    } pgc_dt_e;
    typedef enum logic [1:0] {
        PGC_PM_COMPL = 2'b00,
        PGC_PM_REDUND = 2'b01,
        PGC_PM_PUSHPULL = 2'b10,
        PGC_PM_INDEP = 2'b11
    } pgc_pin_pair_mode_e;
endpackage : pgc_pkg

// ==== core/pgc_dt_if.sv ====
// pgc_dt_if: raw pwm edge pair and dead-time settings passed to the dead-time unit
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface pgc_dt_if;
    logic raw_h;
    logic raw_l;
    logic [1:0] mode;
    logic comp_polarity;
    logic comp_input;
    logic complementary;
    logic [13:0] dead_time_count;
    logic [13:0] alt_dead_time_count;
    logic out_h;
    logic out_l;
    modport gen (output raw_h, raw_l, mode, comp_polarity, comp_input, complementary,
        dead_time_count, alt_dead_time_count, input out_h, out_l);
    modport dtu (input raw_h, raw_l, mode, comp_polarity, comp_input, complementary,
        dead_time_count, alt_dead_time_count, output out_h, out_l);
endinterface : pgc_dt_if

// ==== core/pgc_dead_time.sv ====
// pgc_dead_time: delays output edges by dead-time counts per the control mode
// assumes raw edges from the generator on the same clock; counts in i_mclk ticks
`timescale 1ns/1ps
module pgc_dead_time (
    input wire logic i_mclk,
    input wire logic i_rst,
    pgc_dt_if.dtu dt
);
    logic [13:0] cnt_reg;
    logic h_reg;
    logic l_reg;
    logic [13:0] rise_h_dt;
    logic [13:0] rise_l_dt;
    logic pol_eff;
    logic raw_l_eff;
    logic h_rise;
    logic l_rise;
    // polarity matters only in compensation mode
    assign pol_eff = (dt.mode == pgc_pkg::PGC_DT_COMP) ? dt.comp_polarity : 1'b0;
    // compensation: the shortened output gets the long delay, lengthened one the alternate
    assign rise_h_dt = (dt.mode == pgc_pkg::PGC_DT_COMP) ?
        (((dt.comp_input == 1'b0) == pol_eff) ? dt.alt_dead_time_count : dt.dead_time_count)
        : dt.dead_time_count;
    assign rise_l_dt = (dt.mode == pgc_pkg::PGC_DT_COMP) ?
        (((dt.comp_input == 1'b0) == pol_eff) ? dt.dead_time_count : dt.alt_dead_time_count)
        : dt.alt_dead_time_count;
    assign raw_l_eff = dt.complementary ? ~dt.raw_h : dt.raw_l;
    assign h_rise = dt.raw_h & ~h_reg;
    assign l_rise = raw_l_eff & ~l_reg;
    assign dt.out_h = h_reg;
    assign dt.out_l = l_reg;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cnt_reg <= 14'h0000;
            h_reg <= 1'b0;
            l_reg <= 1'b0;
        end else if (dt.mode == pgc_pkg::PGC_DT_OFF ||
                     (dt.mode == pgc_pkg::PGC_DT_NEG && !dt.complementary)) begin
            h_reg <= dt.raw_h;
            l_reg <= raw_l_eff;
            cnt_reg <= 14'h0000;
        end else if (dt.mode == pgc_pkg::PGC_DT_NEG) begin
            // negative dead time: the hold needs a nonzero count, which is zero at an edge, so edges pass unheld without overlap
            h_reg <= dt.raw_h | (h_reg & cnt_reg != 14'h0000);
            l_reg <= raw_l_eff | (l_reg & cnt_reg != 14'h0000);
            cnt_reg <= (dt.raw_h != h_reg || raw_l_eff != l_reg) ?
                ((cnt_reg == 14'h0000) ? dt.dead_time_count : cnt_reg - 14'h0001) : 14'h0000;
        end else begin
            // positive or compensation: rising edges held back by the count
            if (!dt.raw_h) h_reg <= 1'b0;
            if (!raw_l_eff) l_reg <= 1'b0;
            if (h_rise || l_rise) begin
                if (cnt_reg >= (h_rise ? rise_h_dt : rise_l_dt)) begin
                    h_reg <= dt.raw_h;
                    l_reg <= raw_l_eff;
                    cnt_reg <= 14'h0000;
                end else begin
                    cnt_reg <= cnt_reg + 14'h0001;
                end
            end else begin
                cnt_reg <= 14'h0000;
            end
        end
    end
endmodule : pgc_dead_time

// ==== core/pgc_trigger.sv ====
// pgc_trigger: start delay and divider for adc trigger events
// assumes a one-cycle period pulse and a one-cycle trigger event on i_mclk
`timescale 1ns/1ps
module pgc_trigger (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic i_period,
    input wire logic i_event,
    input wire logic [3:0] i_divider,
    input wire logic [5:0] i_start,
    output logic o_trigger
);
    logic [5:0] wait_reg;
    logic [3:0] div_reg;
    logic en_q_reg;
    logic armed;
    assign armed = en_q_reg && wait_reg == 6'h00;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wait_reg <= 6'h00;
            div_reg <= 4'h0;
            en_q_reg <= 1'b0;
            o_trigger <= 1'b0;
        end else begin
            en_q_reg <= i_enable;
            o_trigger <= 1'b0;
            if (i_enable && !en_q_reg) begin
                wait_reg <= i_start;
                div_reg <= 4'h0;
            end else if (!armed && i_period && wait_reg != 6'h00) begin
                wait_reg <= wait_reg - 6'h01;
            end else if (armed && i_event) begin
                // one pass per divider+1 events
                if (div_reg >= i_divider) begin
                    div_reg <= 4'h0;
                    o_trigger <= 1'b1;
                end else begin
                    div_reg <= div_reg + 4'h1;
                end
            end
        end
    end
endmodule : pgc_trigger

// ==== core/pgc_channel.sv ====
// pgc_channel: one pwm generator channel with apb registers, time base, duty,
// phase, dead time and adc trigger output
// assumes apb master on i_mclk; comp and current-limit inputs are asynchronous pins
`timescale 1ns/1ps
module pgc_channel (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_comp_input,
    input wire logic i_current_limit,
    input wire logic i_primary_sync,
    input wire logic i_secondary_sync,
    output logic o_high_output,
    output logic o_low_output,
    output logic o_adc_trigger,
    output logic o_trigger_irq
);
    logic [15:0] ctrl_reg;
    logic [15:0] duty_reg;
    logic [15:0] lduty_reg;
    logic [15:0] phase_reg;
    logic [15:0] lphase_reg;
    logic [15:0] dt_reg;
    logic [15:0] altdt_reg;
    logic [15:0] trig_reg;
    logic [15:0] cfg_reg;
    logic [15:0] mduty_reg;
    logic [15:0] mper_reg;
    // active copies loaded at period boundary unless immediate update
    logic [15:0] act_duty_reg;
    logic [15:0] act_lduty_reg;
    logic [15:0] act_phase_reg;
    logic [15:0] act_lphase_reg;
    logic [13:0] act_dt_reg;
    logic [13:0] act_altdt_reg;
    logic [15:0] act_mduty_reg;
    logic [15:0] cnt_reg;
    logic [15:0] lcnt_reg;
    logic down_reg;
    logic [1:0] cmp_sync_reg;
    logic [1:0] cl_sync_reg;
    logic [1:0] psync_reg;
    logic [1:0] ssync_reg;
    logic sync_q_reg;
    logic wr;
    logic rd;
    logic hit;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic en;
    logic independent_period_en;
    logic indep;
    logic cam_eff;
    logic sync_lvl;
    logic sync_pulse;
    logic ext_reset;
    logic [15:0] period;
    logic [15:0] lperiod;
    logic wrap;
    logic lwrap;
    logic period_edge;
    logic load;
    logic [15:0] duty_eff;
    logic [15:0] cnt_next;
    logic [15:0] lcnt_next;
    logic down_next;
    logic raw_h;
    logic raw_l;
    logic trig_pulse;
    logic [1:0] pin_pair_mode;
    logic [15:0] ctrl_merged;

    function automatic logic [15:0] pgc_wmerge(input logic [15:0] old, input logic [15:0] d,
        input logic [15:0] mask);
        pgc_wmerge = (old & ~mask) | (d & mask);
    endfunction : pgc_wmerge

    assign wr = i_psel && i_penable && i_pwrite;
    assign rd = i_psel && !i_penable && !i_pwrite;
    assign wdata = i_pwdata[15:0];
    assign ctrl_merged = pgc_wmerge(ctrl_reg, wdata, pgc_pkg::CTRL_WMASK);
    assign en = cfg_reg[pgc_pkg::CFG_EN];
    assign pin_pair_mode = cfg_reg[pgc_pkg::CFG_PIN_PAIR_MODE_LO +: 2];
    assign independent_period_en = ctrl_reg[pgc_pkg::CTRL_ITB];
    assign indep = pin_pair_mode == pgc_pkg::PGC_PM_INDEP;
    assign cam_eff = independent_period_en && ctrl_reg[pgc_pkg::CTRL_CAM];
    assign sync_lvl = ctrl_reg[pgc_pkg::CTRL_TBS] ? ssync_reg[1] : psync_reg[1];
    assign sync_pulse = sync_lvl && !sync_q_reg;
    assign ext_reset = ctrl_reg[pgc_pkg::CTRL_XPR] && independent_period_en && cl_sync_reg[1];
    assign period = independent_period_en ? act_phase_reg : mper_reg;
    assign lperiod = (independent_period_en && indep) ? act_lphase_reg : period;
    assign wrap = cam_eff ? (down_reg && cnt_reg == 16'h0000) : (cnt_reg >= period);
    assign lwrap = lcnt_reg >= lperiod;
    assign period_edge = en && (wrap || (!independent_period_en && sync_pulse) || ext_reset);
    assign load = ctrl_reg[pgc_pkg::CTRL_IUE] || period_edge;
    assign duty_eff = ctrl_reg[pgc_pkg::CTRL_MDS] ? act_mduty_reg : act_duty_reg;
    assign raw_h = en && cnt_reg < duty_eff;
    assign raw_l = en && (indep ? lcnt_reg < act_lduty_reg : raw_h);
    // master time base: the phase offset is the restart point of the shared counter
    assign cnt_next = ext_reset ? 16'h0000 :
        (!independent_period_en && sync_pulse) ? act_phase_reg :
        cam_eff ? (down_reg ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001) :
        wrap ? 16'h0000 : cnt_reg + 16'h0001;
    assign down_next = cam_eff && (down_reg ? cnt_reg != 16'h0001 : cnt_reg + 16'h0001 < period);
    assign lcnt_next = !indep ? cnt_next :
        ext_reset ? 16'h0000 :
        (!independent_period_en && sync_pulse) ? act_lphase_reg :
        lwrap ? 16'h0000 : lcnt_reg + 16'h0001;
    assign hit = i_paddr[1:0] == 2'b00 && i_paddr <= pgc_pkg::OFF_STAT;
    always_comb begin
        case (i_paddr)
            pgc_pkg::OFF_CTRL: rdata = ctrl_reg;
            pgc_pkg::OFF_DUTY: rdata = duty_reg;
            pgc_pkg::OFF_LDUTY: rdata = lduty_reg;
            pgc_pkg::OFF_PHASE: rdata = phase_reg;
            pgc_pkg::OFF_LPHASE: rdata = lphase_reg;
            pgc_pkg::OFF_DT: rdata = dt_reg & pgc_pkg::DT_MASK;
            pgc_pkg::OFF_ALTDT: rdata = altdt_reg & pgc_pkg::DT_MASK;
            pgc_pkg::OFF_TRIG: rdata = trig_reg & pgc_pkg::TRIG_MASK;
            pgc_pkg::OFF_CFG: rdata = cfg_reg;
            pgc_pkg::OFF_MDUTY: rdata = mduty_reg;
            pgc_pkg::OFF_MPER: rdata = mper_reg;
            pgc_pkg::OFF_STAT: rdata = cnt_reg;
            default: rdata = pgc_pkg::RESET_ZERO;
        endcase
    end

    pgc_dt_if dtl ();
    assign dtl.raw_h = raw_h;
    assign dtl.raw_l = raw_l;
    assign dtl.mode = ctrl_reg[pgc_pkg::CTRL_DTC_HI:pgc_pkg::CTRL_DTC_LO];
    assign dtl.comp_polarity = ctrl_reg[pgc_pkg::CTRL_POL];
    assign dtl.comp_input = cmp_sync_reg[1];
    assign dtl.complementary = pin_pair_mode == pgc_pkg::PGC_PM_COMPL;
    assign dtl.dead_time_count = act_dt_reg;
    assign dtl.alt_dead_time_count = act_altdt_reg;

    pgc_dead_time u_dead_time (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .dt(dtl.dtu)
    );

    pgc_trigger u_trigger (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_enable(en),
        .i_period(period_edge),
        .i_event(period_edge),
        .i_divider(trig_reg[pgc_pkg::TRIG_DIV_LO +: 4]),
        .i_start(trig_reg[5:0]),
        .o_trigger(trig_pulse)
    );

    // bus: zero wait states, read data captured in setup for a registered prdata
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && !hit;
            if (rd) o_prdata <= {16'h0000, rdata};
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ctrl_reg <= pgc_pkg::RESET_ZERO;
            duty_reg <= pgc_pkg::RESET_ZERO;
            lduty_reg <= pgc_pkg::RESET_ZERO;
            phase_reg <= pgc_pkg::RESET_ZERO;
            lphase_reg <= pgc_pkg::RESET_ZERO;
            dt_reg <= pgc_pkg::RESET_ZERO;
            altdt_reg <= pgc_pkg::RESET_ZERO;
            trig_reg <= pgc_pkg::RESET_ZERO;
            cfg_reg <= pgc_pkg::RESET_ZERO;
            mduty_reg <= pgc_pkg::RESET_ZERO;
            mper_reg <= pgc_pkg::MPER_RESET;
        end else begin
            // trigger status: a write clearing the enable wins over a hardware set; cleared only by clearing the enable
            ctrl_reg[pgc_pkg::CTRL_TRGSTAT] <= ctrl_reg[pgc_pkg::CTRL_TRGIEN] &&
                (ctrl_reg[pgc_pkg::CTRL_TRGSTAT] ||
                 (trig_pulse && !cfg_reg[pgc_pkg::CFG_SECONDARY]));
            if (wr && i_paddr == pgc_pkg::OFF_CTRL) begin
                ctrl_reg[10:0] <= ctrl_merged[10:0];
                if (!wdata[pgc_pkg::CTRL_TRGIEN]) ctrl_reg[pgc_pkg::CTRL_TRGSTAT] <= 1'b0;
            end
            if (wr && i_paddr == pgc_pkg::OFF_DUTY) duty_reg <= wdata;
            if (wr && i_paddr == pgc_pkg::OFF_LDUTY) lduty_reg <= wdata;
            if (wr && i_paddr == pgc_pkg::OFF_PHASE) phase_reg <= wdata;
            if (wr && i_paddr == pgc_pkg::OFF_LPHASE) lphase_reg <= wdata;
            if (wr && i_paddr == pgc_pkg::OFF_DT) dt_reg <= wdata & pgc_pkg::DT_MASK;
            if (wr && i_paddr == pgc_pkg::OFF_ALTDT) altdt_reg <= wdata & pgc_pkg::DT_MASK;
            if (wr && i_paddr == pgc_pkg::OFF_TRIG) trig_reg <= wdata & pgc_pkg::TRIG_MASK;
            if (wr && i_paddr == pgc_pkg::OFF_CFG) cfg_reg <= wdata & pgc_pkg::CFG_WMASK;
            if (wr && i_paddr == pgc_pkg::OFF_MDUTY) mduty_reg <= wdata;
            if (wr && i_paddr == pgc_pkg::OFF_MPER) mper_reg <= wdata;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            act_duty_reg <= pgc_pkg::RESET_ZERO;
            act_lduty_reg <= pgc_pkg::RESET_ZERO;
            act_phase_reg <= pgc_pkg::RESET_ZERO;
            act_lphase_reg <= pgc_pkg::RESET_ZERO;
            act_dt_reg <= 14'h0000;
            act_altdt_reg <= 14'h0000;
            act_mduty_reg <= pgc_pkg::RESET_ZERO;
        end else if (load) begin
            act_duty_reg <= duty_reg;
            act_lduty_reg <= lduty_reg;
            act_phase_reg <= phase_reg;
            act_lphase_reg <= lphase_reg;
            act_dt_reg <= dt_reg[13:0];
            act_altdt_reg <= altdt_reg[13:0];
            act_mduty_reg <= mduty_reg;
        end
    end

    // pins pass two flops before any logic reads them
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cmp_sync_reg <= 2'b00;
            cl_sync_reg <= 2'b00;
            psync_reg <= 2'b00;
            ssync_reg <= 2'b00;
            sync_q_reg <= 1'b0;
        end else begin
            cmp_sync_reg <= {cmp_sync_reg[0], i_comp_input};
            cl_sync_reg <= {cl_sync_reg[0], i_current_limit};
            psync_reg <= {psync_reg[0], i_primary_sync};
            ssync_reg <= {ssync_reg[0], i_secondary_sync};
            sync_q_reg <= sync_lvl;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst || !en) begin
            cnt_reg <= 16'h0000;
            lcnt_reg <= 16'h0000;
            down_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            lcnt_reg <= lcnt_next;
            down_reg <= down_next;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_high_output <= 1'b0;
            o_low_output <= 1'b0;
            o_adc_trigger <= 1'b0;
            o_trigger_irq <= 1'b0;
        end else begin
            o_high_output <= dtl.out_h;
            // push-pull alternates outputs by period parity is not modelled; same as redundant
            o_low_output <= dtl.out_l;
            o_adc_trigger <= trig_pulse;
            o_trigger_irq <= ctrl_reg[pgc_pkg::CTRL_TRGSTAT];
        end
    end
endmodule : pgc_channel

// ==== verif/pgc_channel_sva.sv ====
// pgc_channel_sva: port checks of the apb slave and pwm outputs
// assumes binding to pgc_channel, one clock, synchronous active-high reset
`timescale 1ns/1ps
module pgc_channel_sva (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_high_output,
    input wire logic o_low_output,
    input wire logic o_adc_trigger,
    input wire logic o_trigger_irq
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // unaligned or past the status word
    wire logic bad_addr = (i_paddr > 8'h2C) || (i_paddr[1:0] != 2'b00);
    sequence setup_s; i_psel && !i_penable; endsequence
    sequence rd_s; o_pready && !i_pwrite; endsequence
    property reset_p;
        disable iff (1'b0) i_rst |=> !(o_high_output || o_low_output || o_adc_trigger
            || o_trigger_irq || o_pready);
    endproperty
    setup_ready_a: assert property (setup_s |=> o_pready && i_penable) else $error("no ready");
    ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("ready held");
    upper_zero_a: assert property (rd_s |-> o_prdata[31:16] == 16'h0000) else $error("upper");
    bad_addr_a: assert property (setup_s ##0 bad_addr |=> o_pslverr) else $error("no error");
    good_addr_a: assert property (setup_s ##0 !bad_addr |=> !o_pslverr) else $error("error");
    dt_top_a: assert property ((rd_s ##0 i_paddr == pgc_pkg::OFF_DT) |-> o_prdata[15:14] == 2'b00)
        else $error("dead time top bits");
    altdt_top_a: assert property ((rd_s ##0 i_paddr == pgc_pkg::OFF_ALTDT) |-> !o_prdata[15])
        else $error("alternate top bit");
    trig_gap_a: assert property ((rd_s ##0 i_paddr == pgc_pkg::OFF_TRIG) |-> !(|o_prdata[11:6]))
        else $error("trigger gap bits");
    ctrl_gap_a: assert property ((rd_s ##0 i_paddr == pgc_pkg::OFF_CTRL) |-> !o_prdata[4])
        else $error("control bit 4");
    trig_pulse_a: assert property (o_adc_trigger |=> !o_adc_trigger) else $error("long trigger");
    reset_quiet_a: assert property (reset_p) else $error("output after reset");
endmodule : pgc_channel_sva

// ==== verif/pgc_stage_model.sv ====
// pgc_stage_model: adc trigger input only, counts cycles and logs trigger pulses
// assumes the channel's registered outputs on the same clock
`timescale 1ns/1ps
module pgc_stage_model (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_trigger,
    output int o_cycle,
    output int o_trig_count,
    output int o_trig_at
);
    // counting cycles here keeps the bench free of its own timers
    always_ff @(posedge i_mclk) begin
        o_cycle <= i_rst ? 0 : o_cycle + 1;
        o_trig_count <= i_rst ? 0 : o_trig_count + int'(i_trigger);
        o_trig_at <= (i_trigger && !i_rst) ? o_cycle : o_trig_at;
    end
endmodule : pgc_stage_model

// ==== verif/testbench.sv ====
// testbench: registers, trigger divider, start delay and dead time of one channel
// assumes pgc_channel with a wait-free apb slave and pgc_stage_model
`timescale 1ns/1ps
module testbench;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic i_comp_input = 1'b0;
    logic i_current_limit = 1'b0;
    logic i_sync_a = 1'b0;
    logic i_sync_b = 1'b0;
    logic [31:0] o_prdata, rdat;
    logic o_pready, o_pslverr, o_high_output, o_low_output, o_adc_trigger, o_trigger_irq, err;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc, trig_count, trig_at, g1, t0, t1, w, d0;
    always #12.5 i_mclk = ~i_mclk;
    pgc_channel pgc_channel_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_comp_input(i_comp_input), .i_current_limit(i_current_limit),
        .i_primary_sync(i_sync_a), .i_secondary_sync(i_sync_b), .o_high_output(o_high_output),
        .o_low_output(o_low_output), .o_adc_trigger(o_adc_trigger), .o_trigger_irq(o_trigger_irq));
    pgc_stage_model pgc_stage_model_inst (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_trigger(o_adc_trigger), .o_cycle(cyc), .o_trig_count(trig_count), .o_trig_at(trig_at));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= {16'h0000, d};
        @(posedge i_mclk);
        i_penable <= 1'b1;
        // only the watchdog ends a wait for ready
        do @(posedge i_mclk); while (o_pready !== 1'b1);
        rdat = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 16'h0000);
        check("read data", rdat, exp);
    endtask : rdchk
    task automatic next_trig(output int t);
        int c0 = trig_count;
        int n = 0;
        while (trig_count == c0 && n < 2000) begin
            @(posedge i_mclk);
            n++;
        end
        t = trig_at;
    endtask : next_trig
    task automatic width(input logic lo, output int wd);
        wd = 0;
        do @(posedge i_mclk); while ((lo ? o_low_output : o_high_output) !== 1'b0 && cyc < 90000);
        do @(posedge i_mclk); while ((lo ? o_low_output : o_high_output) !== 1'b1 && cyc < 90000);
        do begin
            @(posedge i_mclk);
            wd++;
        end while ((lo ? o_low_output : o_high_output) === 1'b1 && wd < 200);
    endtask : width
    task automatic t_regs;
        logic [7:0] offs [8] = '{pgc_pkg::OFF_CTRL, pgc_pkg::OFF_DUTY, pgc_pkg::OFF_LDUTY,
            pgc_pkg::OFF_PHASE, pgc_pkg::OFF_LPHASE, pgc_pkg::OFF_DT, pgc_pkg::OFF_ALTDT,
            pgc_pkg::OFF_TRIG};
        logic [15:0] msk [8] = '{pgc_pkg::CTRL_WMASK, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
            pgc_pkg::DT_MASK, pgc_pkg::DT_MASK, pgc_pkg::TRIG_MASK};
        rdchk(pgc_pkg::OFF_MPER, {16'h0000, pgc_pkg::MPER_RESET});
        for (int i = 0; i < 8; i++) begin
            rdchk(offs[i], 32'h0000_0000);
            apb(1'b1, offs[i], 16'hFFFF);
            rdchk(offs[i], {16'h0000, msk[i]});
            apb(1'b1, offs[i], 16'h0000);
        end
        apb(1'b1, 8'h30, 16'h1234);
        check("unmapped error", err, 1'b1);
        rdchk(8'h02, 32'h0000_0000);
    endtask : t_regs
    task automatic t_pwm;
        apb(1'b1, pgc_pkg::OFF_MPER, 16'h0013);
        apb(1'b1, pgc_pkg::OFF_DUTY, 16'h0008);
        // dead time off, immediate update, trigger interrupt on
        apb(1'b1, pgc_pkg::OFF_CTRL, 16'h0481);
        apb(1'b1, pgc_pkg::OFF_CFG, 16'h0001);
        next_trig(t0);
        next_trig(t1);
        g1 = t1 - t0;
        check("primary irq", o_trigger_irq, 1'b1);
        width(1'b0, w);
        check("high width", 32'(w), 32'd8);
        width(1'b1, w);
        check("low width", 32'(w), 32'(g1 - 8));
        apb(1'b1, pgc_pkg::OFF_DT, 16'h0003);
        apb(1'b1, pgc_pkg::OFF_CTRL, 16'h0401);
        width(1'b0, w);
        width(1'b0, w);
        check("high with dead time", 32'(w), 32'd5);
        for (int d = 3; d < 16; d += 12) begin
            apb(1'b1, pgc_pkg::OFF_TRIG, 16'(d << 12));
            next_trig(t0);
            next_trig(t0);
            next_trig(t1);
            check("divided gap", 32'(t1 - t0), 32'(g1 * (d + 1)));
        end
        apb(1'b1, pgc_pkg::OFF_CTRL, 16'h0001);
        repeat (2) @(posedge i_mclk);
        check("irq cleared", o_trigger_irq, 1'b0);
    endtask : t_pwm
    task automatic t_start;
        for (int s = 0; s < 64; s += (s == 0) ? 2 : 61) begin
            apb(1'b1, pgc_pkg::OFF_CFG, 16'h0000);
            apb(1'b1, pgc_pkg::OFF_TRIG, 16'(s));
            apb(1'b1, pgc_pkg::OFF_CFG, 16'h0001);
            t0 = cyc;
            next_trig(t1);
            if (s == 0) d0 = t1 - t0;
            check("start delay", 32'(t1 - t0 - d0), 32'(s * g1));
        end
    endtask : t_start
    task automatic t_secondary;
        apb(1'b1, pgc_pkg::OFF_CFG, 16'h0000);
        apb(1'b1, pgc_pkg::OFF_TRIG, 16'h0000);
        apb(1'b1, pgc_pkg::OFF_CTRL, 16'h0481);
        apb(1'b1, pgc_pkg::OFF_CFG, 16'h0011);
        next_trig(t0);
        next_trig(t1);
        check("secondary irq", o_trigger_irq, 1'b0);
    endtask : t_secondary
    initial begin
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        t_regs();
        t_pwm();
        t_start();
        t_secondary();
        end_sim();
    end
    // whole run needs under 5000 cycles
    initial begin
        repeat (40000) @(posedge i_mclk);
        fail_count++;
        end_sim();
    end
endmodule : testbench
bind pgc_channel pgc_channel_sva pgc_channel_sva_inst (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_high_output(o_high_output), .o_low_output(o_low_output),
    .o_adc_trigger(o_adc_trigger), .o_trigger_irq(o_trigger_irq));
